// File: verilog/chgcr_regs.sv
// charger control registers: serial slave, register bank 00..0A, watchdog
// assumes SCL/SDA come from open-drain pins; analog side reads CFG
//
// Behaviour
// - slave answers only at seven-bit address 6B; host uses that address.
// - offsets 00 to 07 are readable and writable.
// - offsets 08 to 0A are read-only status taken from inputs.
// - input source bit 7 enables high-impedance mode, resets to zero.
// - input source bits 6:3 hold the input voltage limit code.
// - input source bits 2:0 hold the input current limit code.
// - effective current limit is the lower of register and external pin.
// - port detection loads current limit: SDP by OTG pin, else DCP code.
// - writing one to config bit 7 restores all defaults, bit self-clears.
// - writing one to config bit 6 restarts the watchdog, bit self-clears.
// - watchdog field: 00 off, 01 40s, 10 80s, default 01.
// - config bits 5:4 select charger mode, default charge battery.
// - config bits 3:1 hold minimum system voltage code, default 101.
`timescale 1ns/10ps
`include "chgcr_params.svh"

module chgcr_regs #(
  parameter int unsigned WDT_BASE_CYC = `CHGCR_WDT_BASE_CYC
) (
  input  wire  logic                 CLK_SYS,        // 10 MHz system clock
  input  wire  logic                 RST_B,          // sync reset, active low
  input  wire  logic                 SCL_IN,         // bus clock pin level
  input  wire  logic                 SDA_IN,         // bus data pin level
  output logic                       SDA_OUT,        // data drive value, always 0
  output logic                       SDA_OE_B,       // low while pulling SDA low
  input  wire  logic                 OTG_PIN,        // OTG strap pin level
  input  wire  chgcr_pkg::chgcr_det_t DET,           // detection report, same clock
  input  wire  logic [2:0]           EXT_EXTERNAL_CURRENT_LIMIT_PIN_CODE,  // external pin limit, same clock
  input  wire  logic [23:0]          STATUS_IN,      // status for 0A,09,08
  output chgcr_pkg::chgcr_cfg_t      CFG             // decoded settings
);
  import chgcr_pkg::*;

  // base period must leave the four-times setting inside 32 bits
  if (WDT_BASE_CYC < 1 || WDT_BASE_CYC > 32'd536870911) begin : g_bad_base
    $error("WDT_BASE_CYC out of range");
  end

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] pin_in;
  logic [2:0] s1_q, s2_q, s3_q, flt_q, prev_q;
  logic [2:0] flt_d;

  assign pin_in = {OTG_PIN, SDA_IN, SCL_IN};

  // three stages, filtered value moves when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_comb begin
        flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : flt_q[gi];
      end
    end
  endgenerate

  // sync register stage
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      s1_q   <= 3'h3;
      s2_q   <= 3'h3;
      s3_q   <= 3'h3;
      flt_q  <= 3'h3;
      prev_q <= 3'h3;
    end else begin
      s1_q   <= pin_in;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      flt_q  <= flt_d;
      prev_q <= flt_q;
    end
  end

  logic scl, sda, otg, rise, fall, start, stop;
  assign scl   = flt_q[0];
  assign sda   = flt_q[1];
  assign otg   = flt_q[2];
  assign rise  = scl & ~prev_q[0];
  assign fall  = ~scl & prev_q[0];
  assign start = scl & prev_q[0] & prev_q[1] & ~sda;
  assign stop  = scl & prev_q[0] & ~prev_q[1] & sda;

  // --------------------------------------------------------------------------
  // bus engine and register bank
  // --------------------------------------------------------------------------
  chgcr_state_t st_q, st_d, nxt_q, nxt_d;
  logic [2:0]   cnt_q, cnt_d;
  logic [7:0]   sh_q, sh_d, out_q, out_d, ptr_q, ptr_d;
  logic         done_q, done_d, drv_q, drv_d, kick;
  logic [7:0]   regs_q [0:7];
  logic [7:0]   regs_d [0:7];

  // reset images of offsets 00..07
  localparam logic [7:0] rst_val [0:7] = '{`CHGCR_RST_R0, `CHGCR_RST_R1, `CHGCR_RST_R2,
    `CHGCR_RST_R3, `CHGCR_RST_R4, `CHGCR_RST_R5, `CHGCR_RST_R6, `CHGCR_RST_R7};

  // read mux over the whole map, unmapped reads zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a <= `CHGCR_RW_LAST) begin
      v = regs_q[a[2:0]];
    end else if (a == `CHGCR_RO_FIRST) begin
      v = STATUS_IN[7:0];
    end else if (a == 8'h09) begin
      v = STATUS_IN[15:8];
    end else if (a == `CHGCR_RO_LAST) begin
      v = STATUS_IN[23:16];
    end
    return v;
  endfunction

  // next state of the engine and the bank
  always_comb begin
    st_d   = st_q;
    nxt_d  = nxt_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    out_d  = out_q;
    ptr_d  = ptr_q;
    done_d = done_q;
    drv_d  = drv_q;
    kick   = 1'b0;
    for (int i = 0; i < 8; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (DET.valid) begin
      if (DET.is_sdp) begin
        regs_d[0][`CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_MSB:`CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_LSB] =
          otg ? `CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_SDP_HI : `CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_SDP_LO;
      end else begin
        regs_d[0][`CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_MSB:`CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_LSB] = `CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_DCP;
      end
    end
    if (start) begin
      st_d   = S_ADDR;
      cnt_d  = 3'h0;
      done_d = 1'b0;
      drv_d  = 1'b0;
    end else if (stop) begin
      st_d  = S_IDLE;
      drv_d = 1'b0;
    end else if (rise) begin
      case (st_q)
        S_ADDR, S_PTR, S_WR: begin
          sh_d  = {sh_q[6:0], sda};
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            done_d = 1'b1;
          end
        end
        S_MACK: begin
          if (sda) begin
            st_d = S_IDLE;
          end
        end
        default: ;
      endcase
    end else if (fall) begin
      case (st_q)
        S_ADDR: begin
          if (done_q) begin
            done_d = 1'b0;
            if (sh_q[7:1] == `CHGCR_SLAVE_ADDR) begin
              drv_d = 1'b1;
              st_d  = S_ACK;
              nxt_d = sh_q[0] ? S_RD : S_PTR;
            end else begin
              st_d = S_IDLE;
            end
          end
        end
        S_PTR: begin
          if (done_q) begin
            done_d = 1'b0;
            ptr_d  = sh_q;
            drv_d  = 1'b1;
            st_d   = S_ACK;
            nxt_d  = S_WR;
          end
        end
        S_WR: begin
          if (done_q) begin
            done_d = 1'b0;
            drv_d  = 1'b1;
            st_d   = S_ACK;
            nxt_d  = S_WR;
            ptr_d  = ptr_q + 8'h01;
            if (ptr_q == `CHGCR_OFF_PWRCFG) begin
              kick = sh_q[`CHGCR_KICK_BIT];
              if (sh_q[`CHGCR_REGRST_BIT]) begin
                for (int i = 0; i < 8; i++) begin
                  regs_d[i] = rst_val[i];
                end
              end else begin
                regs_d[1] = {2'b00, sh_q[5:0]};
              end
            end else if (ptr_q <= `CHGCR_RW_LAST) begin
              regs_d[ptr_q[2:0]] = sh_q;
            end
          end
        end
        S_ACK: begin
          drv_d = 1'b0;
          cnt_d = 3'h0;
          st_d  = nxt_q;
          if (nxt_q == S_RD) begin
            out_d = rd_byte(ptr_q);
            drv_d = ~out_d[7];
            ptr_d = ptr_q + 8'h01;
          end
        end
        S_RD: begin
          if (cnt_q == 3'h7) begin
            drv_d = 1'b0;
            st_d  = S_MACK;
          end else begin
            out_d = {out_q[6:0], 1'b0};
            drv_d = ~out_d[7];
            cnt_d = cnt_q + 3'h1;
          end
        end
        S_MACK: begin
          cnt_d = 3'h0;
          st_d  = S_RD;
          out_d = rd_byte(ptr_q);
          drv_d = ~out_d[7];
          ptr_d = ptr_q + 8'h01;
        end
        default: st_d = S_IDLE;
      endcase
    end
  end

  // engine and bank registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      st_q   <= S_IDLE;
      nxt_q  <= S_IDLE;
      cnt_q  <= 3'h0;
      sh_q   <= 8'h00;
      out_q  <= 8'h00;
      ptr_q  <= 8'h00;
      done_q <= 1'b0;
      drv_q  <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= rst_val[i];
      end
    end else begin
      st_q   <= st_d;
      nxt_q  <= nxt_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      out_q  <= out_d;
      ptr_q  <= ptr_d;
      done_q <= done_d;
      drv_q  <= drv_d;
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // --------------------------------------------------------------------------
  // watchdog and effective current limit
  // --------------------------------------------------------------------------
  logic [31:0] wdt_q, wdt_d, wdt_lim;
  logic        exp_q, exp_d;
  logic [2:0]  eff_q, eff_d;
  logic [1:0]  wdt_sel;

  assign wdt_sel = regs_q[5][`CHGCR_WDT_MSB:`CHGCR_WDT_LSB];

  // period select, restart on kick or disable
  always_comb begin
    case (wdt_sel)
      2'h1:    wdt_lim = 32'(WDT_BASE_CYC);
      2'h2:    wdt_lim = 32'(WDT_BASE_CYC) << 1;
      2'h3:    wdt_lim = 32'(WDT_BASE_CYC) << 2;
      default: wdt_lim = 32'h0000_0000;
    endcase
    wdt_d = wdt_q;
    exp_d = exp_q;
    if (kick || wdt_sel == 2'h0) begin
      wdt_d = 32'h0000_0000;
      exp_d = (wdt_sel != 2'h0) && !exp_q && (wdt_q >= wdt_lim - 32'h1); // expiry beats kick
    end else if (wdt_q >= wdt_lim - 32'h1) begin
      exp_d = 1'b1;
    end else begin
      wdt_d = wdt_q + 32'h1;
    end
    eff_d = regs_q[0][`CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_MSB:`CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_LSB];
    if (EXT_EXTERNAL_CURRENT_LIMIT_PIN_CODE < eff_d) begin
      eff_d = EXT_EXTERNAL_CURRENT_LIMIT_PIN_CODE;
    end
  end

  // watchdog and current limit registers
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      wdt_q <= 32'h0000_0000;
      exp_q <= 1'b0;
      eff_q <= 3'h0;
    end else begin
      wdt_q <= wdt_d;
      exp_q <= exp_d;
      eff_q <= eff_d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign SDA_OUT  = 1'b0;
  assign SDA_OE_B = ~drv_q;
  assign CFG.high_impedance_enable  = regs_q[0][`CHGCR_HIZ_BIT];
  assign CFG.input_voltage_limit    = regs_q[0][`CHGCR_VLIM_MSB:`CHGCR_VLIM_LSB];
  assign CFG.input_current_limit    = eff_q;
  assign CFG.charger_mode_select    = regs_q[1][`CHGCR_MODE_MSB:`CHGCR_MODE_LSB];
  assign CFG.minimum_system_voltage = regs_q[1][`CHGCR_SMIN_MSB:`CHGCR_SMIN_LSB];
  assign CFG.boost_limit_high       = regs_q[1][`CHGCR_BOOST_BIT];
  assign CFG.watchdog_expired       = exp_q;

endmodule // chgcr_regs

// File: verilog/chgcr_params.svh
// charger control registers: offsets, field positions, reset values, timing
// assumes inclusion by bare name from the package and the top module
`ifndef CHGCR_PARAMS_SVH
`define CHGCR_PARAMS_SVH

// --------------------------------------------------------------------------
// bus address and register ranges
// --------------------------------------------------------------------------
`define CHGCR_SLAVE_ADDR    7'h6B
`define CHGCR_RW_FIRST      8'h00
`define CHGCR_RW_LAST       8'h07
`define CHGCR_RO_FIRST      8'h08
`define CHGCR_RO_LAST       8'h0A
`define CHGCR_OFF_ISRC      8'h00
`define CHGCR_OFF_PWRCFG    8'h01
`define CHGCR_OFF_TMR       8'h05

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define CHGCR_HIZ_BIT       7
`define CHGCR_VLIM_MSB      6
`define CHGCR_VLIM_LSB      3
`define CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_MSB      2
`define CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_LSB      0
`define CHGCR_REGRST_BIT    7
`define CHGCR_KICK_BIT      6
`define CHGCR_MODE_MSB      5
`define CHGCR_MODE_LSB      4
`define CHGCR_SMIN_MSB      3
`define CHGCR_SMIN_LSB      1
`define CHGCR_BOOST_BIT     0
`define CHGCR_WDT_MSB       5
`define CHGCR_WDT_LSB       4

// --------------------------------------------------------------------------
// reset values and detection defaults
// --------------------------------------------------------------------------
`define CHGCR_RST_R0        8'h30
`define CHGCR_RST_R1        8'h1B
`define CHGCR_RST_R2        8'h60
`define CHGCR_RST_R3        8'h11
`define CHGCR_RST_R4        8'hB2
`define CHGCR_RST_R5        8'h9A
`define CHGCR_RST_R6        8'h00
`define CHGCR_RST_R7        8'h00
`define CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_SDP_LO   3'h0
`define CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_SDP_HI   3'h2
`define CHGCR_EXTERNAL_CURRENT_LIMIT_PIN_DCP      3'h7

// --------------------------------------------------------------------------
// timing: watchdog base period
// --------------------------------------------------------------------------
`define CHGCR_CLK_HZ        10000000
`define CHGCR_WDT_BASE_S    40
`define CHGCR_WDT_BASE_CYC  (`CHGCR_WDT_BASE_S * `CHGCR_CLK_HZ)

`endif

// File: verilog/chgcr_pkg.sv
// charger control registers: shared types
// assumes chgcr_params.svh is on the include path
package chgcr_pkg;
  `include "chgcr_params.svh"

  // bus engine states
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_PTR, S_WR, S_ACK, S_RD, S_MACK
  } chgcr_state_t;

  // decoded settings driven to the analog side
  typedef struct packed {
    logic       high_impedance_enable;
    logic [3:0] input_voltage_limit;
    logic [2:0] input_current_limit;
    logic [1:0] charger_mode_select;
    logic [2:0] minimum_system_voltage;
    logic       boost_limit_high;
    logic       watchdog_expired;
  } chgcr_cfg_t;

  // port detection report from the source detector
  typedef struct packed {
    logic valid;
    logic is_sdp;
  } chgcr_det_t;
endpackage

// File: tb/chgcr_regs_props.sv
// checker of the charger register bank, watching the top ports only
// assumes bus phases of at least 8 clocks and a steady pin limit at detect
`timescale 1ns/10ps
module chgcr_regs_props #(
  parameter int unsigned WDT_BASE_CYC = 200
) (
  input wire logic                  CLK_SYS,       // system clock
  input wire logic                  RST_B,         // sync reset
  input wire logic                  SCL_IN,        // bus clock
  input wire logic                  SDA_IN,        // bus data
  input wire logic                  SDA_OUT,       // data value
  input wire logic                  SDA_OE_B,      // data enable
  input wire logic                  OTG_PIN,       // otg strap
  input wire chgcr_pkg::chgcr_det_t DET,           // detect report
  input wire logic [2:0]            EXT_EXTERNAL_CURRENT_LIMIT_PIN_CODE, // pin limit
  input wire logic [23:0]           STATUS_IN,     // status
  input wire chgcr_pkg::chgcr_cfg_t CFG            // settings
);
  import chgcr_pkg::*;
  // ------------------------------
  // steps and properties
  // ------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // otg level held past its synchroniser
  sequence s_otg(logic v);
    (OTG_PIN == v) [*5];
  endsequence
  // one detect pulse of a kind, pin limit wide open
  sequence s_det(logic sdp);
    DET.valid && DET.is_sdp == sdp && EXT_EXTERNAL_CURRENT_LIMIT_PIN_CODE == 3'h7;
  endsequence
  property p_rst_vals;
    $rose(RST_B) |-> SDA_OE_B && CFG == {1'h0, 4'h6, 3'h0, 2'h1, 3'h5, 1'h1, 1'h0};
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad settings after reset");
  property p_external_current_limit_pin_min;
    CFG.input_current_limit <= $past(EXT_EXTERNAL_CURRENT_LIMIT_PIN_CODE);
  endproperty
  a_external_current_limit_pin_min: assert property (p_external_current_limit_pin_min) else $error("limit above pin limit");
  property p_det_lo;
    s_otg(1'h0) ##0 s_det(1'h1) |-> ##2 CFG.input_current_limit == 3'h0;
  endproperty
  a_det_lo: assert property (p_det_lo) else $error("bad low port default");
  property p_det_hi;
    s_otg(1'h1) ##0 s_det(1'h1) |-> ##2 CFG.input_current_limit == 3'h2;
  endproperty
  a_det_hi: assert property (p_det_hi) else $error("bad high port default");
  property p_det_dcp;
    s_det(1'h0) |-> ##2 CFG.input_current_limit == 3'h7;
  endproperty
  a_det_dcp: assert property (p_det_dcp) else $error("bad charging port default");
  property p_sda_low;
    $changed(SDA_OE_B) |-> !SCL_IN && !$past(SCL_IN, 2) && !SDA_OUT;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data moved with clock high");
  property p_cfg_quiet;
    !$stable({CFG.high_impedance_enable, CFG.input_voltage_limit, CFG.charger_mode_select,
              CFG.minimum_system_voltage, CFG.boost_limit_high}) |-> !SCL_IN;
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet) else $error("settings moved off bus");
  property p_wdt_kick;
    $fell(CFG.watchdog_expired) |-> !SCL_IN;
  endproperty
  a_wdt_kick: assert property (p_wdt_kick) else $error("expiry cleared off bus");
endmodule // chgcr_regs_props
bind chgcr_regs chgcr_regs_props #(.WDT_BASE_CYC(WDT_BASE_CYC)) u_props (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE_B(SDA_OE_B), .OTG_PIN(OTG_PIN), .DET(DET),
  .EXT_EXTERNAL_CURRENT_LIMIT_PIN_CODE(EXT_EXTERNAL_CURRENT_LIMIT_PIN_CODE), .STATUS_IN(STATUS_IN), .CFG(CFG));

// File: tb/chgcr_host.sv
// host processor model: serial bus master with open-drain drives
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/10ps
`include "chgcr_params.svh"
module chgcr_host (
  input  wire logic clk,    // bench clock
  input  wire logic sda_w,  // resolved data wire
  output logic      scl,    // clock drive, 1 releases
  output logic      sda     // data drive, 1 releases
);
  // ------------------------------
  // bus phases
  // ------------------------------
  logic [7:0] res;   // last result byte
  event       done;  // result ready
  // idle bus
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end
  // one phase of 8 clocks
  task automatic hp();
    repeat (8) @(posedge clk);
    #1;
  endtask
  // data set mid low, sampled end of high
  task automatic bit_x(input logic b, output logic r);
    hp();
    sda = b;
    hp();
    scl = 1'h1;
    hp();
    r = sda_w;
    scl = 1'h0;
  endtask
  // start or repeated start
  task automatic start();
    hp();
    sda = 1'h1;
    hp();
    scl = 1'h1;
    hp();
    sda = 1'h0;
    hp();
    scl = 1'h0;
  endtask
  task automatic stop();
    hp();
    sda = 1'h0;
    hp();
    scl = 1'h1;
    hp();
    sda = 1'h1;
  endtask
  // byte out msb first, then the answer bit
  task automatic sb(input logic [7:0] tx, output logic [7:0] rx, output logic nak);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(1'h1, nak);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    logic [7:0] x;
    logic [2:0] n;
    start();
    sb({a, 1'h0}, x, n[2]);
    sb(p, x, n[1]);
    sb(d, x, n[0]);
    stop();
    res = {5'h0, n};
    ->done;
  endtask
  task automatic rd(input logic [7:0] p);
    logic [7:0] x;
    logic       n;
    start();
    sb({`CHGCR_SLAVE_ADDR, 1'h0}, x, n);
    sb(p, x, n);
    start();
    sb({`CHGCR_SLAVE_ADDR, 1'h1}, x, n);
    sb(8'hFF, res, n);
    stop();
    ->done;
  endtask
endmodule // chgcr_host

// File: tb/chgcr_regs_test.sv
// bench of the charger register bank, driven through the host model
// assumes the package and design are compiled first
`timescale 1ns/10ps
`include "chgcr_params.svh"
module chgcr_regs_test;
  import chgcr_pkg::*;
  // ------------------------------
  // signals and instances
  // ------------------------------
  logic        clk_sys = 1'h0;   // system clock
  logic        rst_b = 1'h0;     // sync reset
  logic        otg = 1'h0;       // otg strap
  chgcr_det_t  det = '0;         // detect report
  logic [2:0]  ext = 3'h7;       // pin limit
  logic [23:0] status = 24'h0;   // status inputs
  logic        scl, sda_h, sda_oe_b, sda_out, sda_w;
  chgcr_cfg_t  cfg;              // settings out
  logic [15:0] bq[$], cq[$];     // expected notes
  int          miscompares = 0;
  int          cmp_count = 0;
  logic [31:0] lfsr = 32'h509A;
  logic [7:0]  r0, r1;           // shadows of first two registers
  event        cfg_ev;
  logic [7:0]  rv [8] = '{8'h30, 8'h1B, 8'h60, 8'h11, 8'hB2, 8'h9A, 8'h00, 8'h00};
  // wire with pull-up
  assign sda_w = sda_h & (sda_oe_b | sda_out);
  always #50 clk_sys = ~clk_sys;
  chgcr_regs #(.WDT_BASE_CYC(200)) dut (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out),
    .SDA_OE_B(sda_oe_b), .OTG_PIN(otg), .DET(det), .EXT_EXTERNAL_CURRENT_LIMIT_PIN_CODE(ext),
    .STATUS_IN(status), .CFG(cfg));
  chgcr_host host (.clk(clk_sys), .sda_w(sda_w), .scl(scl), .sda(sda_h));
  // compare each result with the oldest note
  always @(host.done) chk(bq.pop_front(), {8'h0, host.res});
  always @(cfg_ev) chk(cq.pop_front(), {1'h0, cfg});
  // cut a hang short
  initial begin
    repeat (90000) @(posedge clk_sys);
    miscompares++;
    results();
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: expected %0h got %0h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    bq.push_back(16'h0);
    host.wr(`CHGCR_SLAVE_ADDR, p, d);
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    bq.push_back({8'h0, e});
    host.rd(p);
  endtask
  // expected settings from register images
  task automatic ccfg(input logic [7:0] a, input logic [7:0] b, input logic w);
    @(negedge clk_sys);
    cq.push_back({1'h0, a[7:3], (a[2:0] < ext) ? a[2:0] : ext, b[5:0], w});
    ->cfg_ev;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rst();
    rst_b = 1'h0;
    repeat (10) @(posedge clk_sys);
    #1;
    rst_b = 1'h1;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    logic [7:0] t;
    logic [2:0] c;
    int         k;
    rst();
    ccfg(8'h30, 8'h1B, 1'h0);
    for (int i = 0; i < 8; i++) begin
      rd(i[7:0], rv[i]);
      t = rnd();
      if (i == 1) t = t & 8'h3F;
      if (i == 5) t = 8'h8A;
      wr(i[7:0], t);
      rd(i[7:0], t);
    end
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      t = rnd();
      ext = t[2:0];
      r0 = {t[7:3], c};
      r1 = {2'h0, c[1:0], t[3:0]};
      wr(8'h00, r0);
      wr(8'h01, r1 | {1'h0, i == 0, 6'h0});
      ccfg(r0, r1, 1'h0);
    end
    status = {rnd(), rnd(), rnd()};
    wr(8'h08, 8'hFF);
    for (int i = 0; i < 3; i++) rd(8'h08 + i[7:0], status[8 * i +: 8]);
    rd(8'h0B, 8'h00);
    bq.push_back(16'h0007);
    host.wr(7'h6A, 8'h00, 8'hFF);
    rd(8'h00, r0);
    wr(8'h01, 8'h80);
    rd(8'h00, 8'h30);
    rd(8'h01, 8'h1B);
    for (int j = 1; j < 5; j++) begin
      k = j % 4;
      wr(8'h05, {2'h2, k[1:0], 4'hA});
      wr(8'h01, 8'h5B);
      repeat ((k > 0 ? (200 << (k - 1)) : 600) - 45) @(posedge clk_sys);
      ccfg(8'h30, 8'h1B, 1'h0);
      if (k > 0) begin
        repeat (90) @(posedge clk_sys);
        ccfg(8'h30, 8'h1B, 1'h1);
      end
    end
    ext = 3'h7;
    for (int j = 0; j < 3; j++) begin
      otg = j[0];
      repeat (6) @(posedge clk_sys);
      #1;
      det = '{1'h1, j < 2};
      @(posedge clk_sys);
      #1;
      det = '0;
      c = (j == 0) ? 3'h0 : (j == 1) ? 3'h2 : 3'h7;
      rd(8'h00, {5'h06, c});
      ccfg({5'h06, c}, 8'h1B, 1'h0);
    end
    rst();
    ccfg(8'h30, 8'h1B, 1'h0);
    results();
  end
endmodule // chgcr_regs_test
